//--- hdl/tbrt_pkg.sv
// Package of constants and types for the trace buffer read-out and tagging block
package tbrt_pkg;
    // =========================================================
    // Register map (byte addresses)
    localparam logic [7:0] TBRT_OFF_CTRL = 8'h00;
    localparam logic [7:0] TBRT_OFF_PORT = 8'h04;
    localparam logic [7:0] TBRT_OFF_PORT_HIGH = 8'h08;
    localparam logic [7:0] TBRT_OFF_COUNT = 8'h0C;
    localparam logic [7:0] TBRT_OFF_STATUS = 8'h10;
    localparam logic [7:0] TBRT_OFF_COMP = 8'h14;
    // =========================================================
    // Control register fields
    localparam int TBRT_CTRL_ARM = 0;
    localparam int TBRT_CTRL_TRACE_EN = 1;
    localparam int TBRT_CTRL_MODE_LSB = 2;
    localparam int TBRT_CTRL_ALIGN_LSB = 4;
    localparam int TBRT_CTRL_TRIG = 6;
    localparam logic [31:0] TBRT_CTRL_RESET = 32'h0000_0000;
    // Comparator register fields
    localparam int TBRT_COMP_EN = 0;
    localparam int TBRT_COMP_TAG = 1;
    localparam int TBRT_COMP_RANGE = 2;
    localparam int TBRT_COMP_RW_EN = 3;
    localparam int TBRT_COMP_RW = 4;
    localparam int TBRT_COMP_SZ_EN = 5;
    localparam int TBRT_COMP_SZ = 6;
    localparam int TBRT_COMP_ADDR_LSB = 8;
    // =========================================================
    // Information byte fields
    localparam int TBRT_INF_SRC_DST = 7;
    localparam int TBRT_INF_VECTOR = 6;
    localparam int TBRT_INF_VALID = 4;
    localparam int TBRT_XINF_SIZE = 6;
    localparam int TBRT_XINF_RW = 5;
    // =========================================================
    // Timing counts
    localparam logic [5:0] TBRT_MID_LINES = 6'h20;
    // =========================================================
    // Types
    typedef enum logic [1:0] {
        TBRT_MODE_NORMAL = 2'h0,
        TBRT_MODE_LOOP1 = 2'h1,
        TBRT_MODE_DETAIL = 2'h2,
        TBRT_MODE_PURE_PC = 2'h3
    } tbrt_mode_t;
    typedef enum logic [1:0] {
        TBRT_ALIGN_END = 2'h0,
        TBRT_ALIGN_BEGIN = 2'h1,
        TBRT_ALIGN_MID = 2'h2
    } tbrt_align_t;
    typedef enum logic [1:0] {
        TBRT_ST_IDLE = 2'h0,
        TBRT_ST_ARMED = 2'h1,
        TBRT_ST_FINAL = 2'h3,
        TBRT_ST_POST = 2'h2
    } tbrt_state_t;
endpackage

//--- hdl/tbrt_tag_queue.sv
// Instruction queue tag shift register
`timescale 1ns/1ps
module tbrt_tag_queue
    import tbrt_pkg::*;
#(
    parameter int DEPTH = 3
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic CE,
    // Queue control
    input wire logic FETCH,
    input wire logic ADVANCE,
    input wire logic FLUSH,
    input wire logic TAG_IN,
    // Queue head
    output logic HEAD_TAG
);
    typedef struct packed {
        logic [DEPTH-1:0] tags;
    } tbrt_tq_state_t;
    tbrt_tq_state_t s_r;
    tbrt_tq_state_t s_nxt;
    // =========================================================
    // Tags shift toward the head with their opcodes
    always_comb begin
        s_nxt = s_r;
        if (FLUSH) begin
            s_nxt.tags = '0;
        end else if (ADVANCE) begin
            s_nxt.tags = {FETCH & TAG_IN, s_r.tags[DEPTH-1:1]};
        end
    end
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_r <= '0;
        end else if (CE) begin
            s_r <= s_nxt;
        end
    end
    assign HEAD_TAG = s_r.tags[0];
endmodule

//--- hdl/tbrt_top.sv
// Trace buffer read-out, information bytes and instruction tagging
//
// The placing of the registers and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module tbrt_top
    import tbrt_pkg::*;
#(
    parameter int LINES = 64,
    parameter int AW = 23,
    parameter int QDEPTH = 3
) (
    // Clock, reset, enable
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic CE,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Processor trace source
    input wire logic CPU_VALID,
    input wire logic [AW-1:0] CPU_ADDR,
    input wire logic [15:0] CPU_DATA,
    input wire logic CPU_COF,
    input wire logic CPU_DEST,
    input wire logic CPU_VECTOR,
    input wire logic CPU_FETCH,
    input wire logic CPU_FREE,
    input wire logic CPU_BYTE,
    input wire logic CPU_READ,
    input wire logic CPU_EXEC,
    // Instruction queue
    input wire logic IQ_FETCH,
    input wire logic [AW-1:0] IQ_ADDR,
    input wire logic IQ_ADVANCE,
    input wire logic IQ_FLUSH,
    // System
    input wire logic SECURED,
    input wire logic DEBUG_ACTIVE,
    // Debug outputs
    output logic BREAKPOINT,
    output logic ARMED
);
    localparam int LW = $clog2(LINES);
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] comp;
        logic locked;
        logic [LW-1:0] wptr;
        logic [LW-1:0] rptr;
        logic rhalf;
        logic half;
        logic ovf;
        logic [LW+1:0] cnt;
        logic [31:0] pend;
        tbrt_state_t st;
        logic [5:0] post;
        logic brk;
        logic dph;
        logic dwr;
        logic [7:0] daddr;
        logic dalign;
        logic [31:0] rdata;
    } tbrt_state_s_t;
    tbrt_state_s_t s_r;
    tbrt_state_s_t s_nxt;
    logic [63:0] mem_r [LINES];
    logic mem_we;
    logic [LW-1:0] mem_wa;
    logic [63:0] mem_wd;
    logic head_tag;
    // =========================================================
    // Decoded controls and comparator
    tbrt_mode_t mode;
    tbrt_align_t align;
    logic comp_hit;
    logic tag_mark;
    logic trig_now;
    logic tag_hit;
    logic cycle_ok;
    logic [7:0] inf;
    logic [31:0] entry;
    logic rd_ok;
    assign mode = tbrt_mode_t'(s_r.ctrl[TBRT_CTRL_MODE_LSB +: 2]);
    assign align = tbrt_align_t'(s_r.ctrl[TBRT_CTRL_ALIGN_LSB +: 2]);
    assign rd_ok = !s_r.ctrl[TBRT_CTRL_ARM] && s_r.ctrl[TBRT_CTRL_TRACE_EN]
        && !SECURED && !s_r.locked;
    always_comb begin
        comp_hit = CPU_VALID && (CPU_ADDR == s_r.comp[TBRT_COMP_ADDR_LSB +: AW]);
        if (s_r.comp[TBRT_COMP_RW_EN] && (CPU_READ != s_r.comp[TBRT_COMP_RW])) begin
            comp_hit = 1'b0;
        end
        if (s_r.comp[TBRT_COMP_SZ_EN] && (CPU_BYTE != s_r.comp[TBRT_COMP_SZ])) begin
            comp_hit = 1'b0;
        end
        comp_hit = comp_hit && s_r.comp[TBRT_COMP_EN] && !s_r.comp[TBRT_COMP_TAG];
        // Tagged match: opcode address only, access qualifiers ignored
        if (s_r.comp[TBRT_COMP_RANGE]) begin
            tag_mark = IQ_ADDR[AW-1:1] == s_r.comp[TBRT_COMP_ADDR_LSB+1 +: AW-1];
        end else begin
            tag_mark = IQ_ADDR == s_r.comp[TBRT_COMP_ADDR_LSB +: AW];
        end
        tag_mark = tag_mark && s_r.comp[TBRT_COMP_EN] && s_r.comp[TBRT_COMP_TAG]
            && !DEBUG_ACTIVE;
    end
    assign tag_hit = head_tag && CPU_EXEC && !DEBUG_ACTIVE;
    assign trig_now = comp_hit || tag_hit || s_r.ctrl[TBRT_CTRL_TRIG];
    // =========================================================
    // Entry formation
    always_comb begin
        inf = 8'h00;
        cycle_ok = 1'b0;
        if (mode == TBRT_MODE_DETAIL) begin
            cycle_ok = CPU_VALID && !CPU_FETCH && !CPU_FREE;
            inf[TBRT_XINF_SIZE] = CPU_BYTE;
            inf[TBRT_XINF_RW] = CPU_READ;
        end else if (mode == TBRT_MODE_PURE_PC) begin
            cycle_ok = CPU_VALID && CPU_EXEC;
            inf[TBRT_INF_VALID] = 1'b1;
        end else begin
            cycle_ok = CPU_VALID && CPU_COF;
            inf[TBRT_INF_SRC_DST] = CPU_DEST || CPU_VECTOR;
            inf[TBRT_INF_VECTOR] = CPU_VECTOR;
            inf[TBRT_INF_VALID] = 1'b1;
        end
        entry = {inf, {(24-AW){1'b0}}, CPU_ADDR};
    end
    // =========================================================
    // Sequencer, storage and bus
    logic rec;
    logic ap;
    logic aligned;
    logic [LW-1:0] oldest;
    logic [31:0] rword;
    assign ap = HSEL && HREADY && HTRANS[1];
    assign aligned = (HSIZE == 3'h2) && (HADDR[1:0] == 2'h0);
    assign oldest = s_r.ovf ? s_r.wptr : '0;
    assign rword = s_r.rhalf ? mem_r[s_r.rptr][63:32] : mem_r[s_r.rptr][31:0];
    always_comb begin
        s_nxt = s_r;
        mem_we = 1'b0;
        mem_wa = s_r.wptr;
        mem_wd = 64'h0;
        rec = s_r.ctrl[TBRT_CTRL_ARM] && cycle_ok &&
            (s_r.st != TBRT_ST_ARMED || align == TBRT_ALIGN_END
            || align == TBRT_ALIGN_MID);
        s_nxt.brk = 1'b0;
        s_nxt.ctrl[TBRT_CTRL_TRIG] = 1'b0;
        case (s_r.st)
            TBRT_ST_IDLE: begin
                if (s_r.ctrl[TBRT_CTRL_ARM]) begin
                    s_nxt.st = TBRT_ST_ARMED;
                end
            end
            TBRT_ST_ARMED: begin
                if (trig_now) begin
                    if (align == TBRT_ALIGN_END) begin
                        s_nxt.brk = 1'b1;
                        s_nxt.ctrl[TBRT_CTRL_ARM] = 1'b0;
                        s_nxt.st = TBRT_ST_IDLE;
                        rec = 1'b0;
                    end else begin
                        s_nxt.st = TBRT_ST_FINAL;
                        s_nxt.post = '0;
                    end
                end
            end
            TBRT_ST_FINAL: begin
                if (rec && (s_r.half || mode == TBRT_MODE_DETAIL)) begin
                    s_nxt.post = s_r.post + 6'h01;
                end
                if ((align == TBRT_ALIGN_MID && s_r.post == TBRT_MID_LINES)
                    || (align == TBRT_ALIGN_BEGIN && s_r.cnt[LW+1])) begin
                    s_nxt.brk = 1'b1;
                    s_nxt.ctrl[TBRT_CTRL_ARM] = 1'b0;
                    s_nxt.st = TBRT_ST_IDLE;
                    rec = 1'b0;
                end
            end
            default: begin
                s_nxt.st = TBRT_ST_IDLE;
            end
        endcase
        if (rec) begin
            if (mode == TBRT_MODE_DETAIL) begin
                mem_we = 1'b1;
                mem_wd = {inf, {(24-AW){1'b0}}, CPU_ADDR, CPU_DATA, 16'h0000};
                s_nxt.wptr = s_r.wptr + 1'b1;
                s_nxt.cnt = s_r.cnt[LW+1] ? s_r.cnt : s_r.cnt + 2'h2;
                s_nxt.ovf = s_r.ovf || (s_r.wptr == LW'(LINES - 1));
            end else if (!s_r.half) begin
                s_nxt.pend = entry;
                s_nxt.half = 1'b1;
                s_nxt.cnt = s_r.cnt[LW+1] ? s_r.cnt : s_r.cnt + 1'b1;
            end else begin
                mem_we = 1'b1;
                mem_wd = {entry, s_r.pend};
                s_nxt.half = 1'b0;
                s_nxt.wptr = s_r.wptr + 1'b1;
                s_nxt.cnt = s_r.cnt[LW+1] ? s_r.cnt : s_r.cnt + 1'b1;
                s_nxt.ovf = s_r.ovf || (s_r.wptr == LW'(LINES - 1));
            end
        end
        s_nxt.dph = ap;
        if (ap) begin
            s_nxt.dwr = HWRITE;
            s_nxt.daddr = HADDR[7:0];
            s_nxt.dalign = aligned;
        end
        if (ap && !HWRITE) begin
            s_nxt.rdata = 32'h0000_0000;
            case (HADDR[7:0])
                TBRT_OFF_CTRL: s_nxt.rdata = s_r.ctrl;
                TBRT_OFF_COMP: s_nxt.rdata = s_r.comp;
                TBRT_OFF_COUNT: s_nxt.rdata = 32'(s_r.cnt);
                TBRT_OFF_STATUS: s_nxt.rdata = {28'h0, s_r.ovf, s_r.locked,
                    s_r.st};
                TBRT_OFF_PORT, TBRT_OFF_PORT_HIGH: begin
                    if (!aligned) begin
                        s_nxt.rdata = 32'h0000_0000;
                    end else if (s_r.ctrl[TBRT_CTRL_ARM]) begin
                        s_nxt.rdata = 32'hFFFF_FFFF;
                    end else if (rd_ok) begin
                        s_nxt.rdata = rword;
                        s_nxt.rhalf = !s_r.rhalf;
                        if (s_r.rhalf) begin
                            s_nxt.rptr = s_r.rptr + 1'b1;
                        end
                    end
                end
                default: s_nxt.rdata = 32'h0000_0000;
            endcase
        end
        if (s_r.dph && s_r.dwr) begin
            case (s_r.daddr)
                TBRT_OFF_CTRL: begin
                    s_nxt.ctrl = HWDATA;
                    if (HWDATA[TBRT_CTRL_ARM]) begin
                        s_nxt.locked = 1'b1;
                        s_nxt.cnt = '0;
                        s_nxt.wptr = '0;
                        s_nxt.ovf = 1'b0;
                        s_nxt.half = 1'b0;
                    end
                end
                TBRT_OFF_COMP: s_nxt.comp = HWDATA;
                TBRT_OFF_PORT, TBRT_OFF_PORT_HIGH: begin
                    if (s_r.dalign && !s_r.ctrl[TBRT_CTRL_ARM]) begin
                        s_nxt.locked = 1'b0;
                        s_nxt.rptr = oldest;
                        s_nxt.rhalf = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        if (!s_nxt.ctrl[TBRT_CTRL_ARM] && s_r.ctrl[TBRT_CTRL_ARM]) begin
            s_nxt.rptr = oldest;
            s_nxt.rhalf = 1'b0;
        end
    end
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_r.ctrl <= TBRT_CTRL_RESET;
            s_r.comp <= 32'h0000_0000;
            s_r.locked <= 1'b1;
            s_r.rptr <= '0;
            s_r.rhalf <= 1'b0;
            s_r.half <= 1'b0;
            s_r.pend <= 32'h0000_0000;
            s_r.st <= TBRT_ST_IDLE;
            s_r.post <= 6'h00;
            s_r.brk <= 1'b0;
            s_r.dph <= 1'b0;
            s_r.dwr <= 1'b0;
            s_r.daddr <= 8'h00;
            s_r.dalign <= 1'b0;
            s_r.rdata <= 32'h0000_0000;
        end else if (CE) begin
            s_r.ctrl <= s_nxt.ctrl;
            s_r.comp <= s_nxt.comp;
            s_r.locked <= s_nxt.locked;
            s_r.rptr <= s_nxt.rptr;
            s_r.rhalf <= s_nxt.rhalf;
            s_r.half <= s_nxt.half;
            s_r.pend <= s_nxt.pend;
            s_r.st <= s_nxt.st;
            s_r.post <= s_nxt.post;
            s_r.brk <= s_nxt.brk;
            s_r.dph <= s_nxt.dph;
            s_r.dwr <= s_nxt.dwr;
            s_r.daddr <= s_nxt.daddr;
            s_r.dalign <= s_nxt.dalign;
            s_r.rdata <= s_nxt.rdata;
            s_r.wptr <= s_nxt.wptr;
            s_r.cnt <= s_nxt.cnt;
            s_r.ovf <= s_nxt.ovf;
        end
    end
    // Trace storage survives system reset
    always_ff @(posedge CLK) begin
        if (CE) begin
            if (mem_we) begin
                mem_r[mem_wa] <= mem_wd;
            end
        end
    end
    // =========================================================
    // Tag queue
    tbrt_tag_queue #(.DEPTH(QDEPTH)) u_tag_queue (
        .CLK(CLK),
        .RESET_N(RESET_N),
        .CE(CE),
        .FETCH(IQ_FETCH),
        .ADVANCE(IQ_ADVANCE),
        .FLUSH(IQ_FLUSH),
        .TAG_IN(tag_mark),
        .HEAD_TAG(head_tag)
    );
    // =========================================================
    // Outputs
    assign HRDATA = s_r.rdata;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign BREAKPOINT = s_r.brk;
    assign ARMED = s_r.ctrl[TBRT_CTRL_ARM];
endmodule

//--- verification/tbrt_monitor.sv
// Port checker for the trace buffer read-out and tagging block
`timescale 1ns/1ps
module tbrt_monitor
    import tbrt_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // Bus
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    // Debug
    input wire logic BREAKPOINT,
    input wire logic ARMED
);
    // ========================================
    // Sequences
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    sequence s_rd(logic [7:0] a);
        HSEL && HREADY && HTRANS[1] && !HWRITE && HADDR[7:0] == a;
    endsequence
    sequence s_ctrl_wr;
        HSEL && HREADY && HTRANS[1] && HWRITE && HADDR[7:0] == TBRT_OFF_CTRL;
    endsequence
    // ========================================
    // Properties
    property p_ready_high;
        HREADYOUT == 1'b1;
    endproperty
    property p_resp_okay;
        HRESP == 1'b0;
    endproperty
    property p_brk_pulse;
        BREAKPOINT |=> !BREAKPOINT;
    endproperty
    property p_armed_read;
        s_rd(TBRT_OFF_PORT) ##0 (HSIZE == 3'h2 && ARMED) |=> HRDATA == 32'hFFFFFFFF;
    endproperty
    property p_byte_read;
        s_rd(TBRT_OFF_PORT) ##0 (HSIZE != 3'h2) |=> HRDATA == 32'h00000000;
    endproperty
    property p_misaligned;
        s_rd(8'h05) |=> HRDATA == 32'h00000000;
    endproperty
    property p_arm;
        s_ctrl_wr ##1 HWDATA[TBRT_CTRL_ARM] |=> ARMED;
    endproperty
    property p_disarm;
        s_ctrl_wr ##1 !HWDATA[TBRT_CTRL_ARM] |=> !ARMED;
    endproperty
    property p_brk_disarms;
        BREAKPOINT |-> ##[0:1] !ARMED;
    endproperty
    a_ready_high: assert property (p_ready_high) else $error("hreadyout low");
    a_resp_okay: assert property (p_resp_okay) else $error("hresp not okay");
    a_brk_pulse: assert property (p_brk_pulse) else $error("breakpoint too long");
    a_armed_read: assert property (p_armed_read) else $error("armed read data");
    a_byte_read: assert property (p_byte_read) else $error("byte read not zero");
    a_misaligned: assert property (p_misaligned) else $error("misaligned not zero");
    a_arm: assert property (p_arm) else $error("arm not taken");
    a_disarm: assert property (p_disarm) else $error("disarm not taken");
    a_brk_disarms: assert property (p_brk_disarms) else $error("armed after break");
endmodule
bind tbrt_top tbrt_monitor u_mon (.CLK(CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .BREAKPOINT(BREAKPOINT),
    .ARMED(ARMED));

//--- verification/tbrt_host.sv
// Bus master model of the trace reader
`timescale 1ns/1ps
module tbrt_host (
    // Clock and answer
    input wire logic clk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // Master outputs
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    // ========================================
    // Idle state
    initial begin
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
    end
    // ========================================
    // Single transfer
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [2:0] sz,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        hsize <= sz;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        haddr <= ~{24'h000000, a};
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
        hwdata <= ~d;
    endtask
endmodule

//--- verification/tb.sv
// Self-checking testbench for the trace buffer read-out and tagging block
`timescale 1ns/1ps
module tb;
    import tbrt_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic cpu_valid = 0, cpu_cof = 0, cpu_dest = 0, cpu_vector = 0, cpu_fetch = 0;
    logic cpu_free = 0, cpu_byte = 0, cpu_read = 0, cpu_exec = 0;
    logic [22:0] cpu_addr = 23'h0, iq_addr = 23'h0;
    logic [15:0] cpu_data = 16'h0;
    logic iq_fetch = 0, iq_advance = 0, secured = 0, debug_active = 0;
    logic hsel, hwrite, hreadyout, hresp, breakpoint, armed;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int fail_count = 0;
    int comparisons = 0;
    int brk_count = 0;
    // ========================================
    // Clock, design and reader
    initial begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        if (breakpoint === 1'b1) brk_count <= brk_count + 1;
    end
    tbrt_top u_dut (.CLK(clk), .RESET_N(reset_n), .CE(1'b1), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .CPU_VALID(cpu_valid),
        .CPU_ADDR(cpu_addr), .CPU_DATA(cpu_data), .CPU_COF(cpu_cof), .CPU_DEST(cpu_dest),
        .CPU_VECTOR(cpu_vector), .CPU_FETCH(cpu_fetch), .CPU_FREE(cpu_free),
        .CPU_BYTE(cpu_byte), .CPU_READ(cpu_read), .CPU_EXEC(cpu_exec), .IQ_FETCH(iq_fetch),
        .IQ_ADDR(iq_addr), .IQ_ADVANCE(iq_advance), .IQ_FLUSH(1'b0), .SECURED(secured),
        .DEBUG_ACTIVE(debug_active), .BREAKPOINT(breakpoint), .ARMED(armed));
    tbrt_host u_host (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    // ========================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        if (fail_count == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        u_host.xfer(1'b1, a, 3'h2, d, q);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [2:0] sz, input logic [31:0] exp,
                       input logic [31:0] mask);
        logic [31:0] q;
        u_host.xfer(1'b0, a, sz, 32'h00000000, q);
        check(q & mask, exp);
    endtask
    // Flags: cof, dest, vector, byte, read, fetch, free
    task automatic cyc(input logic [22:0] a, input logic [15:0] dt, input logic [6:0] f);
        @(posedge clk);
        cpu_valid <= 1'b1;
        cpu_addr <= a;
        cpu_data <= dt;
        {cpu_cof, cpu_dest, cpu_vector, cpu_byte, cpu_read, cpu_fetch, cpu_free} <= f;
        @(posedge clk);
        cpu_valid <= 1'b0;
        cpu_cof <= 1'b0;
    endtask
    // ========================================
    // Scenarios
    task automatic t_flow;
        wr(TBRT_OFF_CTRL, 32'h00000003);
        cyc(23'h012345, 16'h0000, 7'b1000000);
        cyc(23'h7FFF00, 16'h0000, 7'b1110000);
        rdc(TBRT_OFF_PORT, 3'h2, 32'hFFFFFFFF, 32'hFFFFFFFF);
        wr(TBRT_OFF_CTRL, 32'h00000002);
        rdc(TBRT_OFF_PORT, 3'h2, 32'h00000000, 32'hFFFFFFFF);
        wr(TBRT_OFF_PORT_HIGH, 32'h00000000);
        rdc(TBRT_OFF_PORT, 3'h0, 32'h00000000, 32'hFFFFFFFF);
        rdc(8'h05, 3'h2, 32'h00000000, 32'hFFFFFFFF);
        rdc(TBRT_OFF_COUNT, 3'h2, 32'h00000002, 32'hFFFFFFFF);
        rdc(TBRT_OFF_PORT, 3'h2, 32'h10012345, 32'hFFFFFFFF);
        rdc(TBRT_OFF_PORT, 3'h2, 32'hD07FFF00, 32'hFFFFFFFF);
        rdc(TBRT_OFF_COUNT, 3'h2, 32'h00000002, 32'hFFFFFFFF);
        wr(TBRT_OFF_PORT_HIGH, 32'h00000000);
        rdc(TBRT_OFF_PORT, 3'h2, 32'h10012345, 32'hFFFFFFFF);
        secured <= 1'b1;
        rdc(TBRT_OFF_PORT, 3'h2, 32'h00000000, 32'hFFFFFFFF);
        secured <= 1'b0;
    endtask
    task automatic t_detail;
        wr(TBRT_OFF_CTRL, 32'h0000000B);
        cyc(23'h001234, 16'h00AB, 7'b0001100);
        cyc(23'h005555, 16'h1111, 7'b0000010);
        cyc(23'h006666, 16'h2222, 7'b0000001);
        cyc(23'h004320, 16'h3456, 7'b0000000);
        wr(TBRT_OFF_CTRL, 32'h0000000A);
        wr(TBRT_OFF_PORT_HIGH, 32'h00000000);
        rdc(TBRT_OFF_COUNT, 3'h2, 32'h00000004, 32'hFFFFFFFF);
        rdc(TBRT_OFF_PORT, 3'h2, 32'h00AB0000, 32'hFFFF0000);
        rdc(TBRT_OFF_PORT, 3'h2, 32'h60001234, 32'hFFFFFFFF);
        rdc(TBRT_OFF_PORT, 3'h2, 32'h34560000, 32'hFFFF0000);
        rdc(TBRT_OFF_PORT, 3'h2, 32'h00004320, 32'hFFFFFFFF);
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        wr(TBRT_OFF_CTRL, 32'h0000000A);
        wr(TBRT_OFF_PORT_HIGH, 32'h00000000);
        rdc(TBRT_OFF_COUNT, 3'h2, 32'h00000004, 32'hFFFFFFFF);
        rdc(TBRT_OFF_PORT, 3'h2, 32'h00AB0000, 32'hFFFF0000);
    endtask
    task automatic t_mid;
        int n;
        int b0;
        wr(TBRT_OFF_CTRL, 32'h00000023);
        wr(TBRT_OFF_CTRL, 32'h00000063);
        b0 = brk_count;
        n = 0;
        @(posedge clk);
        cpu_valid <= 1'b1;
        cpu_cof <= 1'b1;
        while (brk_count == b0 && n < 300) begin
            @(posedge clk);
            n++;
        end
        cpu_valid <= 1'b0;
        cpu_cof <= 1'b0;
        check(32'(n >= 64 && n <= 68), 32'h00000001);
        wr(TBRT_OFF_CTRL, 32'h00000000);
    endtask
    task automatic t_tag(input logic [31:0] ctrl, input logic dbg, input int exp);
        int b0;
        wr(TBRT_OFF_COMP, {1'b0, 23'h00ABC0, 8'h0B});
        wr(TBRT_OFF_CTRL, ctrl);
        debug_active <= dbg;
        b0 = brk_count;
        @(posedge clk);
        iq_fetch <= 1'b1;
        iq_addr <= 23'h00ABC0;
        iq_advance <= 1'b1;
        repeat (10) begin
            @(posedge clk);
            iq_addr <= 23'h001000;
            iq_advance <= 1'b1;
            cpu_exec <= 1'b1;
        end
        @(posedge clk);
        {iq_fetch, iq_advance, cpu_exec} <= 3'h0;
        repeat (3) @(posedge clk);
        check(32'(brk_count - b0), 32'(exp));
        wr(TBRT_OFF_CTRL, 32'h00000000);
        debug_active <= 1'b0;
    endtask
    // ========================================
    // Main sequence and watchdog
    initial begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        rdc(TBRT_OFF_PORT, 3'h2, 32'h00000000, 32'hFFFFFFFF);
        t_flow();
        t_detail();
        t_mid();
        t_tag(32'h00000003, 1'b0, 1);
        t_tag(32'h00000003, 1'b1, 0);
        t_tag(32'h00000013, 1'b0, 0);
        close_out();
    end
    initial begin
        #100000;
        fail_count++;
        close_out();
    end
endmodule
